// *** src/aiex_consts.vh ***
// Constants for the add/AND execute slice: opcode fields, register map, flag bits, timing.
// Included by the execute slice and its arithmetic unit; definitions only.
`ifndef AIEX_CONSTS_VH
`define AIEX_CONSTS_VH

// Opcode fields of the 14-bit instruction word
`define AIEX_OP_TOP_LIT 2'h3
`define AIEX_OP_TOP_FILE 2'h0
`define AIEX_OP_ADD_LIT 3'h7
`define AIEX_OP_AND_LIT 4'h9
`define AIEX_OP_ADD_FILE 4'h7
`define AIEX_OP_AND_FILE 4'h5
`define AIEX_DEST_BIT 7

// Decoded operation codes
`define AIEX_DEC_NONE 3'h0
`define AIEX_DEC_ADD_LIT 3'h1
`define AIEX_DEC_AND_LIT 3'h2
`define AIEX_DEC_ADD_FILE 3'h3
`define AIEX_DEC_AND_FILE 3'h4

// Special file addresses
`define AIEX_TIMER_ADDR 7'h01
`define AIEX_PORT_A_ADDR 7'h05
`define AIEX_PORT_B_ADDR 7'h06

// Register byte offsets
`define AIEX_REG_CTRL 8'h00
`define AIEX_REG_WORK 8'h04
`define AIEX_REG_FLAGS 8'h08
`define AIEX_REG_ISSUE 8'h0C
`define AIEX_REG_COUNT 8'h10

// Register select codes
`define AIEX_SEL_CTRL 3'h0
`define AIEX_SEL_WORK 3'h1
`define AIEX_SEL_FLAGS 3'h2
`define AIEX_SEL_ISSUE 3'h3
`define AIEX_SEL_COUNT 3'h4
`define AIEX_SEL_NONE 3'h7

// Field positions
`define AIEX_CTRL_RUN 0
`define AIEX_CTRL_PSC_TMR 1
`define AIEX_FLAG_C 0
`define AIEX_FLAG_DC 1
`define AIEX_FLAG_Z 2
`define AIEX_FLAG_BADOP 3
`define AIEX_ISSUE_PEND 16

// Reset values
`define AIEX_CTRL_RESET 2'h1
`define AIEX_WORK_RESET 8'h00
`define AIEX_FLAGS_RESET 3'h0

// Timing: oscillator periods per instruction cycle
`define AIEX_PHASES 4
`define AIEX_PHASE_LAST 2'h3

// Bus answers
`define AIEX_RESP_OKAY 2'h0
`define AIEX_RESP_SLVERR 2'h2

`endif

// *** src/aiex_alu.v ***
// Arithmetic unit of the add/AND execute slice: 8-bit add or AND with flag results.
// Purely combinational; the caller registers everything it drives out.
`timescale 1ns/10ps
`include "aiex_consts.vh"

module aiex_alu (
	input wire [7:0] op_a, // Working register value
	input wire [7:0] op_b, // Literal or file operand
	input wire do_and, // 1 = AND, 0 = add
	output reg [7:0] result, // 8-bit result
	output reg carry, // Carry out of bit 7
	output reg digit_carry, // Carry out of bit 3
	output reg zero // Result all zeros
);

	reg [8:0] sum;
	reg [4:0] low_sum;

	always @* begin
		sum = {1'b0, op_a} + {1'b0, op_b};
		low_sum = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
		if (do_and) begin
			result = op_a & op_b;
			carry = 1'b0;
			digit_carry = 1'b0;
		end else begin
			result = sum[7:0];
			carry = sum[8];
			digit_carry = low_sum[4];
		end
		zero = (result == 8'h00);
	end

endmodule

// *** src/aiex_exec.v ***
// Execute slice for literal/file add and AND, with an AXI4-Lite register window.
// Assumes a fetch unit offering words on instr_valid/instr_word and a register file
// answering file_raddr on file_rdata within two clocks; aclk is the oscillator clock.
`timescale 1ns/10ps
`include "aiex_consts.vh"

// Function
// - Opcode 11 111x adds the literal to the working register and updates carry, digit carry and zero.
// - Opcode 11 1001 ANDs the literal into the working register and changes only zero.
// - Opcode 00 0111 adds the working register to the addressed file register and updates all three flags.
// - For file operations the result goes to the working register when the destination bit is 0, else to the file.
// - Opcode 00 0101 ANDs the working register with the file register, routes by destination and changes only zero.
// - Each of these instructions completes in one instruction cycle of four oscillator periods.
// - A file write-back to the timer register clears the prescaler when the prescaler is assigned to the timer.
// - When a port register is the source operand, the pin levels are used instead of the output latch.
module aiex_exec (
	input wire aclk, // Oscillator clock, 25 MHz
	input wire aresetn, // Synchronous reset, active low
	input wire ce, // Clock enable, freezes all state when low
	input wire [7:0] s_axi_awaddr, // Write address
	input wire s_axi_awvalid, // Write address valid
	output reg s_axi_awready, // Write address ready
	input wire [31:0] s_axi_wdata, // Write data
	input wire [3:0] s_axi_wstrb, // Write byte strobes
	input wire s_axi_wvalid, // Write data valid
	output reg s_axi_wready, // Write data ready
	output reg [1:0] s_axi_bresp, // Write response
	output reg s_axi_bvalid, // Write response valid
	input wire s_axi_bready, // Write response ready
	input wire [7:0] s_axi_araddr, // Read address
	input wire s_axi_arvalid, // Read address valid
	output reg s_axi_arready, // Read address ready
	output reg [31:0] s_axi_rdata, // Read data
	output reg [1:0] s_axi_rresp, // Read response
	output reg s_axi_rvalid, // Read data valid
	input wire s_axi_rready, // Read data ready
	input wire instr_valid, // Fetch unit offers a word
	input wire [13:0] instr_word, // Instruction word
	output reg instr_ack, // Word taken, one-clock pulse
	output reg [6:0] file_raddr, // File register read address
	input wire [7:0] file_rdata, // File register latch contents
	input wire [7:0] pin_level, // Pin levels of the addressed port
	output reg file_we, // File write strobe, one-clock pulse
	output reg [6:0] file_waddr, // File write address
	output reg [7:0] file_wdata, // File write data
	output reg prescaler_clear, // Prescaler clear, one-clock pulse
	output reg [7:0] work_out, // Working register
	output reg [2:0] flags_out, // Zero, digit carry, carry
	output reg exec_done // Instruction retired, one-clock pulse
);

	localparam PH_FETCH = 2'h0;
	localparam PH_READ = 2'h1;
	localparam PH_OPND = 2'h2;
	localparam PH_EXEC = 2'h3;

	function [2:0] aiex_decode;
		input [13:0] w;
		begin
			if (w[13:12] == `AIEX_OP_TOP_LIT && w[11:9] == `AIEX_OP_ADD_LIT)
				aiex_decode = `AIEX_DEC_ADD_LIT;
			else if (w[13:12] == `AIEX_OP_TOP_LIT && w[11:8] == `AIEX_OP_AND_LIT)
				aiex_decode = `AIEX_DEC_AND_LIT;
			else if (w[13:12] == `AIEX_OP_TOP_FILE && w[11:8] == `AIEX_OP_ADD_FILE)
				aiex_decode = `AIEX_DEC_ADD_FILE;
			else if (w[13:12] == `AIEX_OP_TOP_FILE && w[11:8] == `AIEX_OP_AND_FILE)
				aiex_decode = `AIEX_DEC_AND_FILE;
			else
				aiex_decode = `AIEX_DEC_NONE;
		end
	endfunction

	function [2:0] aiex_reg_sel;
		input [7:0] a;
		begin
			if (a[1:0] != 2'h0)
				aiex_reg_sel = `AIEX_SEL_NONE;
			else if (a == `AIEX_REG_CTRL)
				aiex_reg_sel = `AIEX_SEL_CTRL;
			else if (a == `AIEX_REG_WORK)
				aiex_reg_sel = `AIEX_SEL_WORK;
			else if (a == `AIEX_REG_FLAGS)
				aiex_reg_sel = `AIEX_SEL_FLAGS;
			else if (a == `AIEX_REG_ISSUE)
				aiex_reg_sel = `AIEX_SEL_ISSUE;
			else if (a == `AIEX_REG_COUNT)
				aiex_reg_sel = `AIEX_SEL_COUNT;
			else
				aiex_reg_sel = `AIEX_SEL_NONE;
		end
	endfunction

	reg [1:0] phase_reg;
	reg active_reg;
	reg [2:0] op_reg;
	reg [13:0] ir_reg;
	reg [7:0] operand_reg;
	reg [1:0] ctrl_reg;
	reg badop_reg;
	reg [13:0] issue_reg;
	reg issue_pend_reg;
	reg [15:0] count_reg;
	reg aw_held_reg;
	reg w_held_reg;
	reg [7:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;

	wire [13:0] pick_word = issue_pend_reg ? issue_reg : instr_word;
	wire have_word = issue_pend_reg | instr_valid;
	wire take_word = (phase_reg == PH_FETCH) & ctrl_reg[`AIEX_CTRL_RUN] & have_word;
	wire [6:0] fetch_addr = pick_word[6:0];
	wire is_port = (ir_reg[6:0] == `AIEX_PORT_A_ADDR) || (ir_reg[6:0] == `AIEX_PORT_B_ADDR);
	wire lit_op = (op_reg == `AIEX_DEC_ADD_LIT) || (op_reg == `AIEX_DEC_AND_LIT);
	wire and_op = (op_reg == `AIEX_DEC_AND_LIT) || (op_reg == `AIEX_DEC_AND_FILE);
	wire to_file = ~lit_op & ir_reg[`AIEX_DEST_BIT];
	wire [7:0] alu_b = lit_op ? ir_reg[7:0] : operand_reg;
	wire commit = active_reg & (phase_reg == PH_EXEC) & (op_reg != `AIEX_DEC_NONE);
	wire [7:0] alu_res;
	wire alu_c;
	wire alu_dc;
	wire alu_z;

	aiex_alu u_alu (
		.op_a(work_out),
		.op_b(alu_b),
		.do_and(and_op),
		.result(alu_res),
		.carry(alu_c),
		.digit_carry(alu_dc),
		.zero(alu_z)
	);

	wire do_wr = aw_held_reg & w_held_reg & ~s_axi_bvalid;
	wire [2:0] wr_sel = aiex_reg_sel(aw_addr_reg);
	wire wr_lane0 = do_wr & w_strb_reg[0];
	wire [2:0] rd_sel = aiex_reg_sel(s_axi_araddr);

	always @(posedge aclk) begin
		if (!aresetn) begin
			phase_reg <= PH_FETCH;
			active_reg <= 1'b0;
			op_reg <= `AIEX_DEC_NONE;
			ir_reg <= 14'h0000;
			operand_reg <= 8'h00;
			instr_ack <= 1'b0;
			file_raddr <= 7'h00;
			exec_done <= 1'b0;
		end else if (ce) begin
			phase_reg <= phase_reg + 2'h1;
			instr_ack <= 1'b0;
			exec_done <= 1'b0;
			case (phase_reg)
			PH_FETCH: begin
				if (take_word) begin
					ir_reg <= pick_word;
					op_reg <= aiex_decode(pick_word);
					active_reg <= 1'b1;
					file_raddr <= fetch_addr;
					instr_ack <= ~issue_pend_reg;
				end
			end
			PH_READ: begin
			end
			PH_OPND: begin
				operand_reg <= is_port ? pin_level : file_rdata;
			end
			default: begin
				active_reg <= 1'b0;
				exec_done <= active_reg;
			end
			endcase
		end
	end

	// Result steering and flag update
	always @(posedge aclk) begin
		if (!aresetn) begin
			work_out <= `AIEX_WORK_RESET;
			flags_out <= `AIEX_FLAGS_RESET;
			file_we <= 1'b0;
			file_waddr <= 7'h00;
			file_wdata <= 8'h00;
			prescaler_clear <= 1'b0;
			count_reg <= 16'h0000;
		end else if (ce) begin
			file_we <= 1'b0;
			prescaler_clear <= 1'b0;
			if (commit) begin
				count_reg <= count_reg + 16'h0001;
				if (to_file) begin
					file_we <= 1'b1;
					file_waddr <= ir_reg[6:0];
					file_wdata <= alu_res;
					if (ir_reg[6:0] == `AIEX_TIMER_ADDR && ctrl_reg[`AIEX_CTRL_PSC_TMR])
						prescaler_clear <= 1'b1;
				end else begin
					work_out <= alu_res;
				end
				flags_out[`AIEX_FLAG_Z] <= alu_z;
				if (!and_op) begin
					flags_out[`AIEX_FLAG_C] <= alu_c;
					flags_out[`AIEX_FLAG_DC] <= alu_dc;
				end
			end else if (wr_lane0 && wr_sel == `AIEX_SEL_WORK) begin
				work_out <= w_data_reg[7:0];
			end else if (wr_lane0 && wr_sel == `AIEX_SEL_FLAGS) begin
				flags_out <= w_data_reg[2:0];
			end
		end
	end

	// Control, issue and bad-opcode state
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= `AIEX_CTRL_RESET;
			issue_reg <= 14'h0000;
			issue_pend_reg <= 1'b0;
			badop_reg <= 1'b0;
		end else if (ce) begin
			if (wr_lane0 && wr_sel == `AIEX_SEL_CTRL)
				ctrl_reg <= w_data_reg[1:0];
			// A word written while one is still queued, even in the clock it is taken, is dropped
			if (do_wr && wr_sel == `AIEX_SEL_ISSUE && (w_strb_reg[1:0] == 2'h3) && !issue_pend_reg) begin
				issue_reg <= w_data_reg[13:0];
				issue_pend_reg <= 1'b1;
			end else if (take_word && issue_pend_reg) begin
				issue_pend_reg <= 1'b0;
			end
			// Set beats write-one-to-clear in the same clock
			if (active_reg && phase_reg == PH_EXEC && op_reg == `AIEX_DEC_NONE)
				badop_reg <= 1'b1;
			else if (wr_lane0 && wr_sel == `AIEX_SEL_FLAGS && w_data_reg[`AIEX_FLAG_BADOP])
				badop_reg <= 1'b0;
		end
	end

	// AXI4-Lite write channel, one write in flight
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `AIEX_RESP_OKAY;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
		end else if (ce) begin
			s_axi_awready <= ~aw_held_reg & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
			s_axi_wready <= ~w_held_reg & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Count is read-only, so a write to it is refused too
				if (wr_sel == `AIEX_SEL_NONE || wr_sel == `AIEX_SEL_COUNT)
					s_axi_bresp <= `AIEX_RESP_SLVERR;
				else
					s_axi_bresp <= `AIEX_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel, one read in flight
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `AIEX_RESP_OKAY;
		end else if (ce) begin
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `AIEX_RESP_OKAY;
				s_axi_rdata <= 32'h00000000;
				if (rd_sel == `AIEX_SEL_CTRL)
					s_axi_rdata[1:0] <= ctrl_reg;
				else if (rd_sel == `AIEX_SEL_WORK)
					s_axi_rdata[7:0] <= work_out;
				else if (rd_sel == `AIEX_SEL_FLAGS)
					s_axi_rdata[3:0] <= {badop_reg, flags_out};
				else if (rd_sel == `AIEX_SEL_ISSUE)
					s_axi_rdata <= {15'h0000, issue_pend_reg, 2'h0, issue_reg};
				else if (rd_sel == `AIEX_SEL_COUNT)
					s_axi_rdata[15:0] <= count_reg;
				else
					s_axi_rresp <= `AIEX_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// *** tb/aiex_regfile_model.sv ***
// Register file and port pins beside the execute slice.
// Assumes one clock; reads answer at once, writes land on the strobe edge.
`timescale 1ns/10ps
module aiex_regfile_model (
	input wire aclk, // Core clock
	input wire [6:0] file_raddr, // Read address
	output logic [7:0] file_rdata, // Latch contents
	output logic [7:0] pin_level, // Pin levels
	input wire file_we, // Write strobe
	input wire [6:0] file_waddr, // Write address
	input wire [7:0] file_wdata // Write data
);
	logic [7:0] mem [0:127];
	initial begin
		for (int i = 0; i < 128; i++) mem[i] = 8'hC2;
	end
	// Pins pulled against the latch, so a latch read shows up as a wrong value
	assign file_rdata = mem[file_raddr];
	assign pin_level = ~mem[file_raddr];
	always @(posedge aclk) begin
		if (file_we) mem[file_waddr] <= file_wdata;
	end
endmodule

// *** tb/aiex_exec_monitor.sv ***
// Checker for the execute slice, bound to its ports.
// Assumes no software write to the working register while an instruction runs.
`timescale 1ns/10ps
module aiex_exec_monitor (
	input wire aclk, // Clock
	input wire aresetn, // Reset, active low
	input wire instr_ack, // Word taken
	input wire [13:0] instr_word, // Instruction
	input wire [7:0] work_out, // Working register
	input wire [2:0] flags_out, // Flags
	input wire file_we, // File write
	input wire [6:0] file_waddr, // File address
	input wire prescaler_clear, // Prescaler clear
	input wire exec_done // Retired
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire add_lit = instr_word[13:9] == 5'h1F;
	wire and_lit = instr_word[13:8] == 6'h39;
	wire file_op = instr_word[13:8] == 6'h07 || instr_word[13:8] == 6'h05;
	a_ack_to_done: assert property (instr_ack |-> ##3 exec_done)
		else $error("retire not three cycles after take");
	a_ack_gap: assert property (instr_ack |=> !instr_ack [*3])
		else $error("words taken closer than one instruction cycle");
	a_add_lit_sum: assert property (instr_ack && add_lit |->
		##3 {flags_out[0], work_out} == {1'h0, $past(work_out, 3)} + $past(instr_word[7:0], 3))
		else $error("literal add sum or carry wrong");
	a_and_lit_only_z: assert property (instr_ack && and_lit |->
		##3 work_out == ($past(work_out, 3) & $past(instr_word[7:0], 3))
		&& flags_out[1:0] == $past(flags_out[1:0], 3))
		else $error("literal AND result or carry flags wrong");
	a_lit_zero_flag: assert property (instr_ack && (add_lit || and_lit) |-> ##3 flags_out[2] == (work_out == 8'h00))
		else $error("zero flag does not follow result");
	a_file_dest_one: assert property (instr_ack && file_op && instr_word[7] |->
		##3 file_we && file_waddr == $past(instr_word[6:0], 3) && work_out == $past(work_out, 3))
		else $error("destination one not written to file");
	a_file_dest_zero: assert property (instr_ack && file_op && !instr_word[7] |-> ##3 !file_we)
		else $error("destination zero wrote the file");
	a_presc_timer: assert property (prescaler_clear |-> file_we && file_waddr == 7'h01)
		else $error("prescaler cleared without timer write");
	a_we_retire: assert property (file_we |-> exec_done)
		else $error("file write outside retire");
	c_take: cover property (instr_ack);
	c_file_wr: cover property (file_we);
	c_presc: cover property (prescaler_clear);
endmodule
bind aiex_exec aiex_exec_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .instr_ack(instr_ack),
	.instr_word(instr_word), .work_out(work_out), .flags_out(flags_out), .file_we(file_we),
	.file_waddr(file_waddr), .prescaler_clear(prescaler_clear), .exec_done(exec_done));

// *** tb/aiex_exec_test.sv ***
// Self-checking bench for the execute slice: AXI4-Lite tasks and instruction sequences.
// Assumes the register file model above and a 25 MHz clock.
`timescale 1ns/10ps
module aiex_exec_test;
	logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, ivalid;
	logic [7:0] awaddr, araddr, rdat8;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, iack, fwe, pclr, done;
	logic [13:0] iword;
	logic [6:0] fraddr, fwaddr;
	logic [7:0] frdata, pins, fwdata, work;
	logic [2:0] flags;
	logic [31:0] rd_d;
	logic [1:0] rd_r;
	logic [1:0] wr_r;
	int mismatches = 0, checks_done = 0, pclr_n = 0;
	aiex_exec uut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .instr_valid(ivalid),
		.instr_word(iword), .instr_ack(iack), .file_raddr(fraddr), .file_rdata(frdata), .pin_level(pins),
		.file_we(fwe), .file_waddr(fwaddr), .file_wdata(fwdata), .prescaler_clear(pclr),
		.work_out(work), .flags_out(flags), .exec_done(done));
	aiex_regfile_model u_model (.aclk(aclk), .file_raddr(fraddr), .file_rdata(frdata), .pin_level(pins),
		.file_we(fwe), .file_waddr(fwaddr), .file_wdata(fwdata));
	initial begin
		aclk = 0;
		forever #20 aclk = ~aclk;
	end
	always @(posedge aclk) if (pclr === 1'h1) pclr_n++;
	task chk(input [31:0] g, input [31:0] e);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (bvalid !== 1'h1);
		wr_r = bresp;
		bready <= 0;
	endtask
	task rd(input [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
		end while (rvalid !== 1'h1);
		rd_d = rdata;
		rd_r = rresp;
		rready <= 0;
	endtask
	// Offer one word, hold it until taken, return in the retire cycle
	task exe(input [13:0] w);
		@(posedge aclk);
		ivalid <= 1;
		iword <= w;
		do @(posedge aclk); while (iack !== 1'h1);
		ivalid <= 0;
		do @(posedge aclk); while (done !== 1'h1);
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (4000) @(posedge aclk);
		mismatches++;
		end_of_test;
	end
	initial begin
		aresetn = 0;
		ce = 1;
		awvalid = 0;
		wvalid = 0;
		bready = 0;
		arvalid = 0;
		rready = 0;
		ivalid = 0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		iword = 14'h0000;
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		rd(8'h04);
		chk(rd_d, 32'h0);
		chk(work, 8'h00);
		chk(flags, 3'h0);
		rd(8'h20);
		chk(rd_r, 2'h2);
		chk(rd_d, 32'h0);
		wr(8'h04, 32'h10);
		chk(wr_r, 2'h0);
		exe(14'h3E15);
		chk(work, 8'h25);
		chk(flags, 3'h0);
		wr(8'h04, 32'hF8);
		exe(14'h3F08);
		chk(work, 8'h00);
		chk(flags, 3'h7);
		wr(8'h04, 32'hA3);
		exe(14'h395F);
		chk(work, 8'h03);
		chk(flags, 3'h3);
		wr(8'h04, 32'h17);
		exe(14'h0720);
		chk(work, 8'hD9);
		chk(fwe, 1'h0);
		chk(flags, 3'h0);
		exe(14'h05A1);
		chk(fwe, 1'h1);
		chk(fwaddr, 7'h21);
		chk(fwdata, 8'hC0);
		chk(work, 8'hD9);
		chk(flags, 3'h0);
		wr(8'h04, 32'h3E);
		exe(14'h0781);
		chk(fwdata, 8'h00);
		chk(flags, 3'h7);
		chk(pclr_n, 0);
		wr(8'h00, 32'h3);
		wr(8'h04, 32'h3E);
		exe(14'h0781);
		chk(fwdata, 8'h3E);
		@(posedge aclk);
		chk(pclr_n, 1);
		wr(8'h04, 32'hFF);
		exe(14'h0505);
		chk(work, 8'h3D);
		chk(flags, 3'h0);
		exe(14'h0520);
		chk(work, 8'h00);
		chk(flags, 3'h4);
		chk(fraddr, 7'h20);
		// Unknown opcode takes a slot, leaves work alone, raises the sticky bit
		wr(8'h04, 32'h5A);
		exe(14'h0000);
		chk(work, 8'h5A);
		chk(flags, 3'h4);
		rd(8'h08);
		chk(rd_d, 32'hC);
		wr(8'h08, 32'h8);
		rd(8'h08);
		chk(rd_d, 32'h0);
		rd(8'h10);
		chk(rd_d, 32'h9);
		wr(8'h10, 32'h0);
		chk(wr_r, 2'h2);
		// Queued word held while stopped, then frozen mid-cycle by the enable
		wr(8'h04, 32'h10);
		wr(8'h00, 32'h0);
		wr(8'h0C, 32'h3E05);
		rd(8'h0C);
		chk(rd_d, 32'h00013E05);
		wr(8'h00, 32'h1);
		ce <= 0;
		repeat (6) @(posedge aclk);
		chk(work, 8'h10);
		ce <= 1;
		do @(posedge aclk); while (done !== 1'h1);
		chk(work, 8'h15);
		chk(flags, 3'h0);
		rd(8'h0C);
		chk(rd_d, 32'h00003E05);
		rd(8'h10);
		chk(rd_d, 32'hA);
		end_of_test;
	end
endmodule
